// ===== sgpc_cfg.svh
// Constants for the global and power-management register group
//
// Operation
// [R1] Two-bit field selects internal interface clock rate
// [R2] Host keeps management clock within selected limit
// [R3] Preamble-restore bit enables port-5 10 Mb/s regeneration
// [R4] Tail tag inserts one byte before FCS
// [R5] Pass bit forwards flow-control frames, else filtered
// [R6] PLL power-down field resets to zero, enabled
// [R7] Power field decodes normal, energy, soft-down, saving
// [R8] Host enters soft power-down by plain write
// [R9] Strap at reset loads energy or normal mode
// [R10] Sleep after no-energy lasting delay times 20 ms
// [R11] Sleep-delay register resets to decimal eighty
// [R12] Reserved and test fields read zero, ignore writes
`ifndef SGPC_CFG_SVH
`define SGPC_CFG_SVH
// Register offsets
`define SGPC_ADDR_GIC      8'h0c
`define SGPC_ADDR_TEST     8'h0d
`define SGPC_ADDR_PWR      8'h0e
`define SGPC_ADDR_SLEEP    8'h0f
// Field positions
`define SGPC_CLK_HI        5
`define SGPC_CLK_LO        4
`define SGPC_PRE_BIT       2
`define SGPC_TAIL_BIT      1
`define SGPC_PASS_BIT      0
`define SGPC_PLL_BIT       5
`define SGPC_PM_HI         4
`define SGPC_PM_LO         3
// Reset values
`define SGPC_CLK_RST       2'h1
`define SGPC_PRE_RST       1'h1
`define SGPC_SLEEP_RST     8'h50
`define SGPC_TEST_VAL      8'h00
// Timing: 20 ms unit at 20 MHz
`define SGPC_UNIT_MS       20
`define SGPC_CLK_KHZ       20000
`endif

// ===== sgpc_host_model.sv
// Host model driving the register port of the power register bank
`timescale 1ns/1ps
`default_nettype none
module sgpc_host_model
(
  // Clock
  input  wire logic       sys_clk,
  // Register port
  output logic      [7:0] regAddr,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regWdata,
  input  wire logic [7:0] regRdata
);
  // ----------------------------------
  // Bus cycles
  // ----------------------------------
  // Idle bus at time zero
  initial
  begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 8'h00;
  end
  // Plain single-byte write, never a read-modify-write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(posedge sys_clk) #1;
    regWrite = 1'b0;
  endtask
  // Single read; data taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk) #1;
    regAddr = a;
    regRead = 1'b1;
    @(posedge sys_clk) #1;
    regRead = 1'b0;
    d = regRdata;
  endtask
  // Register port runs on the system clock, no serial rate limit here
endmodule
`default_nettype wire

// ===== sgpc_pkg.sv
// Types for the global and power-management register group
package sgpc_pkg;
  // Power management modes
  typedef enum logic [1:0] {
    SGPC_PM_NORMAL = 2'h0,
    SGPC_PM_ENERGY = 2'h1,
    SGPC_PM_SOFTDN = 2'h2,
    SGPC_PM_SAVING = 2'h3
  } sgpc_pm_t;
  // Interface clock choices
  typedef enum logic [1:0] {
    SGPC_CLK_41 = 2'h0,
    SGPC_CLK_83 = 2'h1,
    SGPC_CLK_125 = 2'h2,
    SGPC_CLK_RSV = 2'h3
  } sgpc_clk_t;
  // Energy-detect sleeper states, one-hot
  typedef enum logic [2:0] {
    SGPC_ST_IDLE  = 3'h1,
    SGPC_ST_COUNT = 3'h2,
    SGPC_ST_SLEEP = 3'h4
  } sgpc_st_t;
endpackage

// ===== sgpc_regs.sv
// Global interface control and power management register bank
`timescale 1ns/1ps
`default_nettype none
`include "sgpc_cfg.svh"
module sgpc_regs
  import sgpc_pkg::*;
#(
  parameter int UNIT_CYCLES = (`SGPC_UNIT_MS * `SGPC_CLK_KHZ)
)
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  // Register port
  input  wire logic [7:0]            regAddr,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  input  wire logic [7:0]            regWdata,
  output var  logic [7:0]            regRdata,
  // Strap and energy pins
  input  wire logic                  pmStrapPin,
  input  wire logic                  noEnergyPin,
  // Controls to the switch
  output var  sgpc_pkg::sgpc_clk_t   ifClkSel,
  output var  logic                  port5PreambleRestore,
  output var  logic                  port5TailTag,
  output var  logic                  passFlowCtrl,
  output var  logic                  pllPowerDown,
  output var  sgpc_pkg::sgpc_pm_t    powerMode,
  output var  logic                  lowPowerSleep
);
  import sgpc_pkg::*;

  logic [1:0]  clk_ff;
  logic        pre_ff;
  logic        tail_ff;
  logic        pass_ff;
  logic        pll_ff;
  logic [1:0]  pm_ff;
  logic [7:0]  sleep_ff;
  logic [1:0]  strapSync_ff;
  logic [1:0]  nrgSync_ff;
  logic        strapDone_ff;
  logic [31:0] div_ff;
  logic        tick_ff;
  logic [7:0]  nxt_rdata;

  sgpc_sleep_if sl();

  // Two-flop synchronisers for pins
  always_ff @(posedge sys_clk)
  begin
    strapSync_ff <= {strapSync_ff[0], pmStrapPin};
    nrgSync_ff   <= {nrgSync_ff[0], noEnergyPin};
  end

  // Strap taken once after reset release
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      strapDone_ff <= 1'b0;
    else
      strapDone_ff <= 1'b1;
  end

  // Interface control fields
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      clk_ff  <= `SGPC_CLK_RST; // see [R1]
      pre_ff  <= `SGPC_PRE_RST; // see [R3]
      tail_ff <= 1'b0;          // see [R4]
      pass_ff <= 1'b0;          // see [R5]
    end
    else if (regWrite && regAddr == `SGPC_ADDR_GIC)
    begin
      clk_ff  <= regWdata[`SGPC_CLK_HI:`SGPC_CLK_LO]; // see [R1]
      pre_ff  <= regWdata[`SGPC_PRE_BIT];             // see [R3]
      tail_ff <= regWdata[`SGPC_TAIL_BIT];            // see [R4]
      pass_ff <= regWdata[`SGPC_PASS_BIT];            // see [R5]
    end
  end

  // Power management fields
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pll_ff <= 1'b0;            // see [R6]
      pm_ff  <= SGPC_PM_NORMAL;
    end
    else if (!strapDone_ff)
      pm_ff <= strapSync_ff[1] ? SGPC_PM_NORMAL : SGPC_PM_ENERGY; // see [R9]
    else if (regWrite && regAddr == `SGPC_ADDR_PWR)
    begin
      pll_ff <= regWdata[`SGPC_PLL_BIT];             // see [R6]
      pm_ff  <= regWdata[`SGPC_PM_HI:`SGPC_PM_LO];   // see [R7] [R8]
    end
  end

  // Sleep delay register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      sleep_ff <= `SGPC_SLEEP_RST; // see [R11]
    else if (regWrite && regAddr == `SGPC_ADDR_SLEEP)
      sleep_ff <= regWdata;
  end

  // 20 ms unit tick
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || div_ff == UNIT_CYCLES - 1)
      div_ff <= 32'h0;
    else
      div_ff <= div_ff + 32'h1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      tick_ff <= 1'b0;
    else
      tick_ff <= (div_ff == UNIT_CYCLES - 1);
  end

  // Read data mux, reserved bits zero
  always_comb
  begin
    nxt_rdata = 8'h00;
    unique case (regAddr)
      `SGPC_ADDR_GIC:   nxt_rdata = {2'h0, clk_ff, 1'b0, pre_ff, tail_ff, pass_ff};
      `SGPC_ADDR_TEST:  nxt_rdata = `SGPC_TEST_VAL;             // see [R12]
      `SGPC_ADDR_PWR:   nxt_rdata = {2'h0, pll_ff, pm_ff, 3'h0}; // see [R12]
      `SGPC_ADDR_SLEEP: nxt_rdata = sleep_ff;
      default:          nxt_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      regRdata <= 8'h00;
    else if (regRead)
      regRdata <= nxt_rdata;
  end

  // Registered control outputs
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ifClkSel             <= SGPC_CLK_83;
      port5PreambleRestore <= 1'b1;
      port5TailTag         <= 1'b0;
      passFlowCtrl         <= 1'b0;
      pllPowerDown         <= 1'b0;
      powerMode            <= SGPC_PM_NORMAL;
      lowPowerSleep        <= 1'b0;
    end
    else
    begin
      ifClkSel             <= sgpc_clk_t'(clk_ff);
      port5PreambleRestore <= pre_ff;
      port5TailTag         <= tail_ff;
      passFlowCtrl         <= pass_ff;
      pllPowerDown         <= pll_ff;
      powerMode            <= sgpc_pm_t'(pm_ff);
      lowPowerSleep        <= sl.sleep;
    end
  end

  // Sleeper hookup
  assign sl.enable   = (pm_ff == SGPC_PM_ENERGY); // see [R10]
  assign sl.delay    = sleep_ff;
  assign sl.noEnergy = nrgSync_ff[1];
  assign sl.tick     = tick_ff;

  sgpc_sleep_timer u_timer (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sl      (sl)
  );

  // Cycles of unbroken no-energy while enabled, for the sleep check
  logic [31:0] quietCnt_ff;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !(sl.enable && sl.noEnergy))
      quietCnt_ff <= 32'h0;
    else if (quietCnt_ff != 32'hffffffff)
      quietCnt_ff <= quietCnt_ff + 32'h1;
  end

  // Host writes to the two control registers
  sequence gicWrite_s;
    regWrite && regAddr == `SGPC_ADDR_GIC;
  endsequence
  sequence pwrWrite_s;
    strapDone_ff && regWrite && regAddr == `SGPC_ADDR_PWR;
  endsequence

  // Write reaches fields one edge later and outputs two edges later
  gic_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    gicWrite_s |-> ##2 port5TailTag == $past(regWdata[`SGPC_TAIL_BIT], 2)) // see [R4]
    else $error("tail tag not updated");
  clk_field_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    gicWrite_s |=> clk_ff == $past(regWdata[`SGPC_CLK_HI:`SGPC_CLK_LO])) // see [R1]
    else $error("clock field not written");
  preamble_out_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    gicWrite_s |-> ##2 port5PreambleRestore == $past(regWdata[`SGPC_PRE_BIT], 2)) // see [R3]
    else $error("preamble output mismatch");
  pass_out_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    gicWrite_s |-> ##2 passFlowCtrl == $past(regWdata[`SGPC_PASS_BIT], 2)) // see [R5]
    else $error("pass flow output mismatch");
  pll_rst_a: assert property (@(posedge sys_clk)
    $fell(sys_rst) |-> pll_ff == 1'b0 && sleep_ff == `SGPC_SLEEP_RST) // see [R6] [R11]
    else $error("bad reset values");
  strap_load_a: assert property (@(posedge sys_clk)
    $fell(sys_rst) |=> pm_ff == (strapSync_ff[1] ? SGPC_PM_NORMAL : SGPC_PM_ENERGY)
      || $past(strapSync_ff[1]) != strapSync_ff[1]) // see [R9]
    else $error("strap not loaded");
  pm_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pwrWrite_s |=> pm_ff == $past(regWdata[`SGPC_PM_HI:`SGPC_PM_LO])) // see [R7]
    else $error("power mode not written");
  pll_out_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pwrWrite_s |-> ##2 pllPowerDown == $past(regWdata[`SGPC_PLL_BIT], 2)) // see [R6]
    else $error("pll output not updated");
  test_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    regRead && regAddr == `SGPC_ADDR_TEST |=> regRdata == `SGPC_TEST_VAL) // see [R12]
    else $error("test byte not zero");
  // Sleep only after the full programmed no-energy period
  sleep_min_time_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(sl.sleep) |-> quietCnt_ff >= 32'(sleep_ff) * UNIT_CYCLES) // see [R10]
    else $error("sleep entered before delay elapsed");
endmodule
`default_nettype wire

// ===== sgpc_sleep_if.sv
// Interface between register bank and energy-detect sleeper
`timescale 1ns/1ps
`default_nettype none
interface sgpc_sleep_if;
  logic       enable;
  logic [7:0] delay;
  logic       noEnergy;
  logic       tick;
  logic       sleep;
  modport regs (output enable, output delay, output noEnergy, output tick, input sleep);
  modport timer (input enable, input delay, input noEnergy, input tick, output sleep);
endinterface
`default_nettype wire

// ===== sgpc_sleep_timer.sv
// Energy-detect sleep timer counting 20 ms units
`timescale 1ns/1ps
`default_nettype none
module sgpc_sleep_timer
  import sgpc_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Link to register bank
  sgpc_sleep_if.timer sl
);
  sgpc_st_t   state_ff;
  sgpc_st_t   nxt_state;
  logic [7:0] units_ff;
  logic       sleep_ff;

  assign sl.sleep = sleep_ff;

  // Next state of the sleeper
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      SGPC_ST_IDLE:
        if (sl.enable && sl.noEnergy)
          nxt_state = SGPC_ST_COUNT;
      SGPC_ST_COUNT:
        if (!sl.enable || !sl.noEnergy)
          nxt_state = SGPC_ST_IDLE;
        // One extra tick covers the partial first unit
        else if (sl.tick && (units_ff >= sl.delay))
          nxt_state = SGPC_ST_SLEEP; // see [R10]
      SGPC_ST_SLEEP:
        if (!sl.enable || !sl.noEnergy)
          nxt_state = SGPC_ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_ff <= SGPC_ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Unit ticks seen during continuous no-energy, the first one partial
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || state_ff != SGPC_ST_COUNT)
      units_ff <= 8'h00;
    else if (sl.tick && units_ff != 8'hff)
      units_ff <= units_ff + 8'h01; // see [R10]
  end

  // Low-power flag
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      sleep_ff <= 1'b0;
    else
      sleep_ff <= (nxt_state == SGPC_ST_SLEEP);
  end

  // Sleep only when enabled and idle of energy
  sleep_needs_energy_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sleep_ff |-> $past(sl.enable) && $past(sl.noEnergy)) // see [R10]
    else $error("sleep without no-energy condition");
  // Entry needs enough counted units
  sleep_delay_min_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(sleep_ff) |-> $past(units_ff) >= $past(sl.delay)) // see [R10]
    else $error("sleep entered too early");
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the global and power register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sgpc_pkg::*;
  // ----------------------------------
  // Signals and instances
  // ----------------------------------
  logic       sys_clk;
  logic       sys_rst;
  logic [7:0] regAddr;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic       pmStrapPin;
  logic       noEnergyPin;
  sgpc_clk_t  ifClkSel;
  logic       pre;
  logic       tail;
  logic       pass;
  logic       pll;
  sgpc_pm_t   powerMode;
  logic       lowPowerSleep;
  logic [7:0] d;
  int         nErrors;
  int         checkCount;
  int         n;
  localparam int UNIT = 10;
  sgpc_regs #(.UNIT_CYCLES(UNIT)) sgpc_regs_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .pmStrapPin(pmStrapPin),
    .noEnergyPin(noEnergyPin), .ifClkSel(ifClkSel), .port5PreambleRestore(pre), .port5TailTag(tail),
    .passFlowCtrl(pass), .pllPowerDown(pll), .powerMode(powerMode), .lowPowerSleep(lowPowerSleep));
  sgpc_host_model sgpc_host_model_i (.sys_clk(sys_clk), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata));
  // Clock of 50 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ----------------------------------
  // Helpers
  // ----------------------------------
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic endSim();
    $display("checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset with a given strap level, two edges fill the strap sync
  task automatic doReset(input logic strap);
    pmStrapPin = strap;
    sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk) #1;
    sys_rst = 1'b0;
  endtask
  // Let a write reach the output pins
  task automatic settle();
    repeat (2) @(posedge sys_clk) #1;
  endtask
  // Count cycles until sleep reaches a level, bounded
  task automatic waitSleep(input logic lvl, input int lim);
    n = 0;
    while (lowPowerSleep !== lvl && n < lim)
    begin
      @(posedge sys_clk) #1;
      n++;
    end
  endtask
  // ----------------------------------
  // Tests
  // ----------------------------------
  initial
  begin
    nErrors = 0;
    checkCount = 0;
    noEnergyPin = 1'b0;
    doReset(1'b1);
    settle();
    chk({6'h0, ifClkSel}, 8'h01);
    chk({4'h0, pre, tail, pass, pll}, 8'h08);
    chk({6'h0, powerMode}, 8'h00);
    sgpc_host_model_i.rd(8'h0c, d);
    chk(d, 8'h14);
    sgpc_host_model_i.rd(8'h0f, d);
    chk(d, 8'h50);
    $display("test reset values done");
    for (int v = 0; v < 3; v++)
    begin
      sgpc_host_model_i.wr(8'h0c, {2'h3, v[1:0], 4'hf});
      settle();
      chk({3'h0, ifClkSel, pre, tail, pass}, {3'h0, v[1:0], 3'h7});
      sgpc_host_model_i.rd(8'h0c, d);
      chk(d, {2'h0, v[1:0], 4'h7});
    end
    sgpc_host_model_i.wr(8'h0c, 8'h00);
    settle();
    chk({5'h0, pre, tail, pass}, 8'h00);
    sgpc_host_model_i.wr(8'h0d, 8'hff);
    settle();
    chk({3'h0, ifClkSel, pre, tail, pass}, 8'h00);
    sgpc_host_model_i.rd(8'h0d, d);
    chk(d, 8'h00);
    sgpc_host_model_i.rd(8'h20, d);
    chk(d, 8'h00);
    $display("test global control done");
    for (int m = 0; m < 4; m++)
    begin
      sgpc_host_model_i.wr(8'h0e, {2'h3, m[0], m[1:0], 3'h7});
      settle();
      chk({5'h0, pll, powerMode}, {5'h0, m[0], m[1:0]});
      sgpc_host_model_i.rd(8'h0e, d);
      chk(d, {2'h0, m[0], m[1:0], 3'h0});
    end
    sgpc_host_model_i.wr(8'h0e, 8'h10);
    settle();
    chk({6'h0, powerMode}, 8'h02);
    sgpc_host_model_i.wr(8'h0e, 8'h00);
    noEnergyPin = 1'b1;
    waitSleep(1'b1, 60);
    chk({7'h0, lowPowerSleep}, 8'h00);
    noEnergyPin = 1'b0;
    $display("test power control done");
    doReset(1'b0);
    settle();
    chk({6'h0, powerMode}, 8'h01);
    chk({6'h0, ifClkSel}, 8'h01);
    sgpc_host_model_i.wr(8'h0f, 8'h03);
    sgpc_host_model_i.rd(8'h0f, d);
    chk(d, 8'h03);
    noEnergyPin = 1'b1;
    repeat (15) @(posedge sys_clk) #1;
    noEnergyPin = 1'b0;
    waitSleep(1'b1, 60);
    chk({7'h0, lowPowerSleep}, 8'h00);
    noEnergyPin = 1'b1;
    waitSleep(1'b1, 200);
    if (lowPowerSleep !== 1'b1)
    begin
      nErrors++;
      $display("BAD t=%0t sleep not reached in time", $time);
    end
    else
      chk({7'h0, n >= 3 * UNIT && n <= 4 * UNIT + 5}, 8'h01);
    noEnergyPin = 1'b0;
    waitSleep(1'b0, 8);
    chk({7'h0, lowPowerSleep}, 8'h00);
    $display("test energy sleep done");
    endSim();
  end
endmodule
`default_nettype wire
